// File: core/rcb_top.sv
// RTC/CMOS logical device config registers on an AXI4-Lite slave
// Assumes reset requests come from logic on clk; main_power_good is a pin
// What this block does
// - Base high holds bank 1 address bits 11:8 in bits 3:0, upper nibble zero.
// - Base low holds address bits 7:1 in bits 7:1, bit 0 always zero.
// - Base low loads 0x74 on main, PCI and soft reset, 0x00 on standby reset.
// - Base high clears to zero on every one of the four resets.
// - Lock bits 0 to 3 each lock one 32-byte block of CMOS RAM.
// - A set lock bit cannot be cleared by any write.
// - Lock bits clear only on main reset, main power loss or PCI reset.
// - Host access to a locked block is denied while main power stays up and bank 1 is active.
// - The shadow register reads the bank 0 index; writes do nothing.
// - Activate bit 0 enables bank 0 decode, bit 1 the bank 1 decode.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "rcb_params.svh"

module rcb_top
    import rcb_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic standby_power_on_reset,
    input wire logic pci_reset,
    input wire logic soft_reset,
    input wire logic main_power_good,
    input wire logic [7:0] bank0_index,
    input wire logic io_cycle,
    input wire logic [`RCB_IO_ADDR_W-1:0] io_addr,
    input wire logic cmos_req,
    input wire logic [`RCB_CMOS_ADDR_W-1:0] cmos_addr,
    output logic bank0_decode_en,
    output logic bank1_decode_en,
    output logic bank1_claim,
    output logic bank1_data_sel,
    output logic cmos_grant,
    output logic cmos_deny,
    input wire logic [`RCB_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`RCB_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic pwr_meta;
    logic pwr_sync;
    logic [1:0] activate;
    logic [3:0] base_high;
    logic [6:0] base_low;
    rcb_byte_t shadow;
    rcb_lock_if lk();

    // Main power pin is asynchronous: two flops before use
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pwr_meta <= 1'b0;
        end else begin
            pwr_meta <= main_power_good;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pwr_sync <= 1'b0;
        end else begin
            pwr_sync <= pwr_meta;
        end
    end

    // Reset groups
    wire main_rst = ~nrst;
    wire cfg_rst = main_rst | pci_reset | soft_reset;
    wire any_rst = cfg_rst | standby_power_on_reset;

    // Address decode, word aligned
    wire [7:0] wr_idx = s_axi_awaddr[9:2];
    wire [7:0] rd_idx = s_axi_araddr[9:2];
    wire wr_top_zero = (s_axi_awaddr[`RCB_ADDR_W-1:10] == 2'h0);
    wire rd_top_zero = (s_axi_araddr[`RCB_ADDR_W-1:10] == 2'h0);
    wire wr_aligned = (s_axi_awaddr[1:0] == 2'h0) & wr_top_zero;
    wire rd_aligned = (s_axi_araddr[1:0] == 2'h0) & rd_top_zero;

    // Index compares, one per mapped word and channel
    wire wr_hit_act = (wr_idx == `RCB_IDX_ACTIVATE);
    wire wr_hit_high = (wr_idx == `RCB_IDX_BASE_HIGH);
    wire wr_hit_low = (wr_idx == `RCB_IDX_BASE_LOW);
    wire wr_hit_lock = (wr_idx == `RCB_IDX_LOCK);
    wire wr_hit_shadow = (wr_idx == `RCB_IDX_SHADOW);
    wire rd_hit_act = (rd_idx == `RCB_IDX_ACTIVATE);
    wire rd_hit_high = (rd_idx == `RCB_IDX_BASE_HIGH);
    wire rd_hit_low = (rd_idx == `RCB_IDX_BASE_LOW);
    wire rd_hit_lock = (rd_idx == `RCB_IDX_LOCK);
    wire rd_hit_shadow = (rd_idx == `RCB_IDX_SHADOW);

    rcb_reg_sel_t wr_sel;
    rcb_reg_sel_t rd_sel;
    assign wr_sel = !wr_aligned ? RCB_REG_NONE :
        wr_hit_act ? RCB_REG_ACT :
        wr_hit_high ? RCB_REG_HIGH :
        wr_hit_low ? RCB_REG_LOW :
        wr_hit_lock ? RCB_REG_LOCK :
        wr_hit_shadow ? RCB_REG_SHADOW : RCB_REG_NONE;
    assign rd_sel = !rd_aligned ? RCB_REG_NONE :
        rd_hit_act ? RCB_REG_ACT :
        rd_hit_high ? RCB_REG_HIGH :
        rd_hit_low ? RCB_REG_LOW :
        rd_hit_lock ? RCB_REG_LOCK :
        rd_hit_shadow ? RCB_REG_SHADOW : RCB_REG_NONE;

    // Write channel: both address and data must be present
    wire next_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready &
        ~s_axi_bvalid;
    wire wr_fire = s_axi_awvalid & s_axi_awready & s_axi_wvalid &
        s_axi_wready;
    // Only byte lane 0 carries register data
    wire wr_en = wr_fire & s_axi_wstrb[0];
    wire [7:0] wb = s_axi_wdata[7:0];
    // One strobe per register keeps each update block short
    wire wr_act = wr_en && wr_sel == RCB_REG_ACT;
    wire wr_high = wr_en && wr_sel == RCB_REG_HIGH;
    wire wr_low = wr_en && wr_sel == RCB_REG_LOW;
    wire wr_lock = wr_en && wr_sel == RCB_REG_LOCK;
    // Unmapped words answer an error rather than vanish quietly
    wire [1:0] next_bresp = (wr_sel == RCB_REG_NONE) ?
        `RCB_RESP_SLVERR : `RCB_RESP_OKAY;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= next_awready;
            s_axi_wready <= next_awready;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_axi_bresp <= `RCB_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bresp <= next_bresp;
        end
    end

    // Activate register, cleared by all four resets
    always_ff @(posedge clk) begin
        if (any_rst) begin
            activate <= `RCB_ACT_RST;
        end else if (wr_act) begin
            activate <= wb[1:0];
        end
    end

    // Bank 1 base high: only address bits 11:8 are stored
    always_ff @(posedge clk) begin
        if (any_rst) begin
            base_high <= `RCB_HIGH_RST;
        end else if (wr_high) begin
            base_high <= wb[3:0];
        end
    end

    // Base low: standby reset wins, it marks a cold start
    wire [7:0] low_rst_val = `RCB_LOW_RST_MAIN;
    wire [7:0] low_stby_val = `RCB_LOW_RST_STBY;
    always_ff @(posedge clk) begin
        if (standby_power_on_reset) begin
            base_low <= low_stby_val[7:1];
        end else if (cfg_rst) begin
            base_low <= low_rst_val[7:1];
        end else if (wr_low) begin
            base_low <= wb[7:1];
        end
    end

    // Shadow follows the bank 0 index every cycle; no write path
    always_ff @(posedge clk) begin
        if (!nrst) begin
            shadow <= `RCB_SHADOW_RST;
        end else begin
            shadow <= bank0_index;
        end
    end

    // Lock block hookup; standby and soft resets leave locks alone
    // Power loss is seen two cycles late through the synchroniser
    assign lk.wr = wr_lock;
    assign lk.wdata = wb;
    assign lk.clear = main_rst | pci_reset | ~pwr_sync;
    // Host access checked only for an active bank 1
    assign lk.req = cmos_req & activate[`RCB_ACT_BANK1_BIT];
    assign lk.addr = cmos_addr;

    rcb_lock u_lock (
        .clk(clk),
        .lk(lk)
    );

    // Read data mux; reserved bits and unmapped words read zero
    wire [7:0] rd_act_img = {6'h00, activate};
    wire [7:0] rd_high_img = {4'h0, base_high};
    wire [7:0] rd_low_img = {base_low, 1'b0};
    wire [7:0] rd_lock_img = {4'h0, lk.lock};
    rcb_byte_t rd_byte;
    assign rd_byte =
        (rd_sel == RCB_REG_ACT) ? rd_act_img :
        (rd_sel == RCB_REG_HIGH) ? rd_high_img :
        (rd_sel == RCB_REG_LOW) ? rd_low_img :
        (rd_sel == RCB_REG_LOCK) ? rd_lock_img :
        (rd_sel == RCB_REG_SHADOW) ? shadow : 8'h00;
    // Error reads carry zero data beside the error code
    wire [1:0] next_rresp = (rd_sel == RCB_REG_NONE) ?
        `RCB_RESP_SLVERR : `RCB_RESP_OKAY;

    wire next_arready = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
    wire rd_fire = s_axi_arvalid & s_axi_arready;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= next_arready;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RCB_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= next_rresp;
        end
    end

    // I/O claim: 16-bit qualification, so bits 15:12 must be zero
    wire io_upper_zero = (io_addr[15:12] == 4'h0);
    wire io_match = io_upper_zero &&
        io_addr[11:1] == {base_high, base_low};

    wire next_claim = io_cycle & io_match &
        activate[`RCB_ACT_BANK1_BIT];

    // Decode enables registered so every output leaves a flop
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bank0_decode_en <= 1'b0;
            bank1_decode_en <= 1'b0;
        end else begin
            bank0_decode_en <= activate[`RCB_ACT_BANK0_BIT];
            bank1_decode_en <= activate[`RCB_ACT_BANK1_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            bank1_claim <= 1'b0;
        end else begin
            bank1_claim <= next_claim;
        end
    end

    // Odd address is the data port, even the index port
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bank1_data_sel <= 1'b0;
        end else begin
            bank1_data_sel <= io_addr[0];
        end
    end

    assign cmos_grant = lk.grant;
    assign cmos_deny = lk.deny;
endmodule

// File: core/rcb_params.svh
// Offsets, field positions, reset values for the RTC/CMOS bank config block
// Assumes inclusion by bare name from package and modules
`ifndef RCB_PARAMS_SVH
`define RCB_PARAMS_SVH

// Register indices; byte address is four times the index
`define RCB_IDX_ACTIVATE 8'h30
`define RCB_IDX_BASE_HIGH 8'h62
`define RCB_IDX_BASE_LOW 8'h63
`define RCB_IDX_LOCK 8'hf0
`define RCB_IDX_SHADOW 8'hf1

`define RCB_ADDR_W 12
`define RCB_IO_ADDR_W 16

// Field positions
`define RCB_ACT_BANK0_BIT 0
`define RCB_ACT_BANK1_BIT 1
`define RCB_LOCK_BITS 4
`define RCB_CMOS_ADDR_W 7

// Reset values
`define RCB_ACT_RST 2'h0
`define RCB_HIGH_RST 4'h0
`define RCB_LOW_RST_MAIN 8'h74
`define RCB_LOW_RST_STBY 8'h00
`define RCB_LOCK_RST 4'h0
`define RCB_SHADOW_RST 8'h00

// Bus answers
`define RCB_RESP_OKAY 2'h0
`define RCB_RESP_SLVERR 2'h2

`endif

// File: core/rcb_pkg.sv
// Types shared by the RTC/CMOS bank config modules
// Assumes rcb_params.svh on the include path
`include "rcb_params.svh"

package rcb_pkg;
    typedef logic [7:0] rcb_byte_t;
    typedef logic [`RCB_LOCK_BITS-1:0] rcb_lock_t;
    typedef logic [`RCB_CMOS_ADDR_W-1:0] rcb_cmos_addr_t;
    typedef logic [1:0] rcb_resp_t;
    typedef enum logic [2:0] {
        RCB_REG_NONE = 3'b000,
        RCB_REG_ACT = 3'b001,
        RCB_REG_HIGH = 3'b010,
        RCB_REG_LOW = 3'b011,
        RCB_REG_LOCK = 3'b100,
        RCB_REG_SHADOW = 3'b101
    } rcb_reg_sel_t;
endpackage

// File: core/rcb_lock_if.sv
// Carrier between the register bank and the CMOS block lock
// Assumes both ends clocked by the same clk
`timescale 1ns/1ps

interface rcb_lock_if;
    import rcb_pkg::*;
    logic wr;
    rcb_byte_t wdata;
    logic clear;
    rcb_lock_t lock;
    logic req;
    rcb_cmos_addr_t addr;
    logic grant;
    logic deny;

    modport bank (output wr, output wdata, output clear, output req,
        output addr, input lock, input grant, input deny);
    modport locker (input wr, input wdata, input clear, input req,
        input addr, output lock, output grant, output deny);
endinterface

// File: core/rcb_lock.sv
// Set-only lock over four 32-byte CMOS RAM blocks and its access check
// Assumes clear already combines main reset, power loss and PCI reset
`timescale 1ns/1ps
`include "rcb_params.svh"

module rcb_lock
    import rcb_pkg::*;
(
    input wire logic clk,
    rcb_lock_if.locker lk
);
    rcb_lock_t lock;
    logic grant;
    logic deny;
    rcb_lock_t next_lock;
    wire hit_locked;

    // Writes may only add lock bits; reserved bits are dropped
    assign next_lock = lock | lk.wdata[`RCB_LOCK_BITS-1:0];
    // Address bits 6:5 pick the 32-byte block
    assign hit_locked = lock[lk.addr[6:5]];

    always_ff @(posedge clk) begin
        if (lk.clear) begin
            lock <= `RCB_LOCK_RST;
        end else if (lk.wr) begin
            lock <= next_lock;
        end
    end

    always_ff @(posedge clk) begin
        if (lk.clear) begin
            grant <= 1'b0;
            deny <= 1'b0;
        end else begin
            grant <= lk.req & ~hit_locked;
            deny <= lk.req & hit_locked;
        end
    end

    assign lk.lock = lock;
    assign lk.grant = grant;
    assign lk.deny = deny;
endmodule

// File: dv/rcb_top_assertions.sv
// Checker on the ports of the RTC/CMOS config block
// Assumes one clk domain, nrst synchronous active low
`timescale 1ns/1ps
module rcb_top_assertions (
    input wire logic clk,
    input wire logic nrst,
    input wire logic main_power_good,
    input wire logic io_cycle,
    input wire logic [15:0] io_addr,
    input wire logic cmos_req,
    input wire logic bank1_decode_en,
    input wire logic bank1_claim,
    input wire logic bank1_data_sel,
    input wire logic cmos_grant,
    input wire logic cmos_deny,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    claim_cause_a: assert property (bank1_claim |->
        $past(io_cycle) && $past(io_addr[15:12]) == 4'h0)
        else $error("stray claim");
    claim_active_a: assert property (bank1_claim |-> bank1_decode_en)
        else $error("claim while bank 1 off");
    sel_follow_a: assert property (io_cycle |=>
        bank1_data_sel == $past(io_addr[0])) else $error("bad port select");
    answer_excl_a: assert property (!(cmos_grant && cmos_deny))
        else $error("grant and deny together");
    answer_cause_a: assert property ((cmos_grant || cmos_deny) |->
        $past(cmos_req)) else $error("answer without request");
    answer_active_a: assert property ((cmos_grant || cmos_deny) |->
        bank1_decode_en) else $error("answer while bank 1 off");
    // Six cycles covers the two-flop sync plus the lock clear
    power_loss_a: assert property (!main_power_good [*6] |->
        !cmos_deny) else $error("deny after power loss");
    rdata_upper_a: assert property (s_axi_rvalid |->
        s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
endmodule
bind rcb_top rcb_top_assertions u_chk (.*);

// File: dv/rcb_host.sv
// Host model: AXI4-Lite master configuring the block
// Assumes the bench runs one wr or rd at a time
`timescale 1ns/1ps
module rcb_host (
    input wire logic clk,
    output logic [11:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [11:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid,
        s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    // Each channel let go only at the edge that takes it
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin
                do @(posedge clk); while (!s_axi_awready);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(posedge clk); while (!s_axi_wready);
                s_axi_wvalid <= 1'b0;
            end
        join
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask
endmodule

// File: dv/rtc_cmos_bank_config_tb_top.sv
// Self-checking bench for the RTC/CMOS config block
// Assumes rcb_host as bus master and the bound checker
`timescale 1ns/1ps
`include "rcb_params.svh"
module rtc_cmos_bank_config_tb_top;
    import rcb_pkg::*;
    localparam logic [11:0] a_act = 12'(4 * `RCB_IDX_ACTIVATE);
    localparam logic [11:0] a_hi = 12'(4 * `RCB_IDX_BASE_HIGH);
    localparam logic [11:0] a_lo = 12'(4 * `RCB_IDX_BASE_LOW);
    localparam logic [11:0] a_lk = 12'(4 * `RCB_IDX_LOCK);
    localparam logic [11:0] a_sh = 12'(4 * `RCB_IDX_SHADOW);
    localparam logic [1:0] ok = `RCB_RESP_OKAY;
    localparam logic [1:0] er = `RCB_RESP_SLVERR;
    logic clk = 0, nrst = 0, standby_power_on_reset = 0, pci_reset = 0;
    logic soft_reset = 0, main_power_good = 1, io_cycle = 0, cmos_req = 0;
    logic [7:0] bank0_index = 0;
    logic [15:0] io_addr = 0;
    logic [6:0] cmos_addr = 0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic bank0_decode_en, bank1_decode_en, bank1_claim, bank1_data_sel;
    logic cmos_grant, cmos_deny, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, seen = 0;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [3:0] eq[$];
    int fail_count = 0, comparisons = 0, seed = 27826, cyc = 0;
    rcb_top u_dut (.*);
    rcb_host u_host (.*);
    always #10 clk = ~clk;
    task automatic finish_test();
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [11:0] a, input logic [7:0] d,
            input logic [1:0] e);
        bq.push_back(e);
        u_host.wr(a, {24'h0, d});
    endtask
    task automatic r(input logic [11:0] a, input logic [7:0] d,
            input logic [1:0] e);
        rq.push_back({e, 24'h0, d});
        u_host.rd(a);
    endtask
    // Expected e is {claim, grant, deny}; port select follows a[0]
    task automatic ev(input logic io, input logic [15:0] a,
            input logic [6:0] c, input logic [2:0] e);
        @(posedge clk);
        io_cycle <= io;
        cmos_req <= !io;
        io_addr <= a;
        cmos_addr <= c;
        eq.push_back({e[2], a[0], e[1:0]});
        @(posedge clk);
        io_cycle <= 1'b0;
        cmos_req <= 1'b0;
    endtask
    task automatic rst(input logic [2:0] v);
        @(posedge clk);
        {standby_power_on_reset, pci_reset, soft_reset} <= v;
        @(posedge clk);
        {standby_power_on_reset, pci_reset, soft_reset} <= 3'b0;
        @(posedge clk);
    endtask
    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        end
        if (s_axi_bvalid && s_axi_bready) begin
            check(34'(s_axi_bresp), 34'(bq.pop_front()));
        end
        if (seen) begin
            check({bank1_claim, bank1_data_sel, cmos_grant, cmos_deny},
                34'(eq.pop_front()));
        end
        seen <= io_cycle || cmos_req;
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    initial begin
        logic [7:0] hi, lo, ix;
        logic [10:0] b;
        logic [6:0] c;
        logic [3:0] m;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        r(a_act, 8'h00, ok);
        r(a_hi, 8'h00, ok);
        r(a_lo, 8'h74, ok);
        r(a_lk, 8'h00, ok);
        hi = 8'($random(seed));
        lo = 8'($random(seed));
        w(a_hi, hi, ok);
        w(a_lo, lo, ok);
        r(a_hi, {4'h0, hi[3:0]}, ok);
        r(a_lo, {lo[7:1], 1'b0}, ok);
        s_axi_wstrb <= 4'he;
        w(a_hi, ~hi, ok);
        s_axi_wstrb <= 4'hf;
        r(a_hi, {4'h0, hi[3:0]}, ok);
        w(12'h004, 8'h55, er);
        r(12'h004, 8'h00, er);
        ix = 8'($random(seed));
        bank0_index <= ix;
        w(a_sh, ~ix, ok);
        r(a_sh, ix, ok);
        b = {hi[3:0], lo[7:1]};
        w(a_act, 8'h01, ok);
        check({bank0_decode_en, bank1_decode_en}, 2'b10);
        ev(1'b1, {4'h0, b, 1'b0}, 7'h0, 3'b000);
        ev(1'b0, 16'h0, 7'h0, 3'b000);
        w(a_act, 8'h03, ok);
        check({bank0_decode_en, bank1_decode_en}, 2'b11);
        ev(1'b1, {4'h0, b, 1'b0}, 7'h0, 3'b100);
        ev(1'b1, {4'h0, b, 1'b1}, 7'h0, 3'b100);
        ev(1'b1, {4'h0, b ^ 11'h1, 1'b1}, 7'h0, 3'b000);
        ev(1'b1, {4'h1, b, 1'b0}, 7'h0, 3'b000);
        m = 4'h0;
        for (int k = 0; k < 4; k++) begin
            c = {k[1:0], 5'($random(seed))};
            ev(1'b0, 16'h0, c, 3'b010);
            w(a_lk, 8'(1 << k), ok);
            ev(1'b0, 16'h0, c, 3'b001);
            w(a_lk, 8'h00, ok);
            m[k] = 1'b1;
            r(a_lk, {4'h0, m}, ok);
        end
        rst(3'b001);
        r(a_lk, 8'h0f, ok);
        r(a_lo, 8'h74, ok);
        r(a_hi, 8'h00, ok);
        r(a_act, 8'h00, ok);
        rst(3'b100);
        r(a_lo, 8'h00, ok);
        r(a_lk, 8'h0f, ok);
        rst(3'b010);
        r(a_lk, 8'h00, ok);
        r(a_lo, 8'h74, ok);
        w(a_lk, 8'h0a, ok);
        main_power_good <= 1'b0;
        repeat (8) @(posedge clk);
        main_power_good <= 1'b1;
        repeat (3) @(posedge clk);
        r(a_lk, 8'h00, ok);
        repeat (3) @(posedge clk);
        finish_test();
    end
endmodule
